/* src/pin_cell.sv */
// one pin: function select register and output steering
module pin_cell
  import pin_mux_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sel_we,
  input  wire logic [2:0] sel_wdata,
  input  wire logic       alt_out1,
  input  wire logic       alt_out2,
  input  wire logic       alt_out3,
  input  wire logic       force_out,
  input  wire logic       force_oe,
  input  wire logic       force_en,
  output logic [2:0]      sel_q,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            alt_in_en
);
  // ************************************************************
  // select register
  // ************************************************************
  // reset leaves the pin as a floating input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= FN_RESET;
    end else if (sel_we) begin
      sel_q <= sel_wdata;
    end
  end

  // ************************************************************
  // output steering
  // ************************************************************
  // driver stays off unless an output function is chosen or force_en hands it force_oe
  always_comb begin
    pin_out   = 1'b0;
    pin_oe    = 1'b0;
    alt_in_en = 1'b0;
    if (force_en) begin
      pin_out = force_out;
      pin_oe  = force_oe;
    end else begin
      unique case (sel_q)
        3'(fn_gp_input):    pin_oe = 1'b0;
        3'(fn_alt_input):   alt_in_en = 1'b1;
        3'(fn_alt_output1): begin
          pin_out = alt_out1;
          pin_oe  = 1'b1;
        end
        3'(fn_alt_output2): begin
          pin_out = alt_out2;
          pin_oe  = 1'b1;
        end
        3'(fn_alt_output3): begin
          pin_out = alt_out3;
          pin_oe  = 1'b1;
        end
        default:            pin_oe = 1'b0; // illegal codes stay undriven
      endcase
    end
  end
endmodule

/* src/pin_mux_pkg.sv */
package pin_mux_pkg;
  // ************************************************************
  // port geometry
  // ************************************************************
  localparam int NUM_PORTS     = 10;
  localparam int PORT_BITS     = 8;
  localparam int NUM_PINS      = NUM_PORTS * PORT_BITS;
  // port numbers used by the external memory bus
  localparam int EXT_ADDR_HI_PORT = 7;
  localparam int EXT_DATA_PORT    = 8;
  localparam int EXT_ADDR_MID_PORT = 9;
  // byte lanes of the external bus address and data words
  localparam int EXT_LOW_LSB    = 0;
  localparam int EXT_MID_LSB    = 8;
  localparam int EXT_HIGH_LSB   = 16;
  // firmware write port: pin index and select code widths
  localparam int SEL_IDX_BITS   = 7;
  localparam int SEL_BITS       = 3;

  // ************************************************************
  // per-pin function select codes
  // ************************************************************
  typedef enum logic [2:0] {
    fn_gp_input,
    fn_alt_input,
    fn_alt_output1,
    fn_alt_output2,
    fn_alt_output3
  } pin_fn_e;
  localparam logic [2:0] FN_RESET = 3'h0;

  // external memory bus modes
  typedef enum logic [1:0] {
    bus_off,
    bus_8bit_nonmux,
    bus_16bit_mux
  } bus_mode_e;

  // ************************************************************
  // polarity vector layout, one bit per signal group
  // ************************************************************
  localparam int POL_IRQ    = 0;
  localparam int POL_ALE    = 1;
  localparam int POL_CAPT   = 2;
  localparam int POL_CMP    = 3;
  localparam int POL_TACH   = 4;
  localparam int POL_ESTOP  = 5;
  localparam int POL_PHASE  = 6;
  localparam int POL_BITS   = 7;
  localparam int NUM_IRQ    = 8;
  localparam int NUM_CAPT   = 8;
  localparam int NUM_CMP    = 8;
  localparam int NUM_PHASE  = 6;
endpackage

/* src/port_pin_function_mux.sv */
module port_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              nrst,
  // firmware select write port
  input  wire logic                              sel_we,
  input  wire logic [6:0]                        sel_pin,
  input  wire logic [2:0]                        sel_wdata,
  output logic [pin_mux_pkg::NUM_PINS*3-1:0]     sel_state,
  // pad side
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  pad_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0]       pad_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0]       pad_oe,
  output logic [pin_mux_pkg::NUM_PINS-1:0]       gpio_in_q,
  // peripheral side
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  alt_out1,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  alt_out2,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  alt_out3,
  output logic [pin_mux_pkg::NUM_PINS-1:0]       default_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0]       alt_in,
  // external memory bus
  input  wire logic [1:0]                        ext_bus_mode,
  input  wire logic [23:0]                       ext_bus_addr,
  input  wire logic [15:0]                       ext_bus_wdata,
  input  wire logic                              ext_bus_data_oe,
  input  wire logic                              ext_bus_addr_phase,
  output logic [15:0]                            ext_bus_rdata_q,
  input  wire logic                              ext_bus_addr_latch_raw,
  output logic                                   ext_bus_addr_latch,
  input  wire logic                              ext_bus_low_wr_raw,
  input  wire logic                              ext_bus_high_wr_raw,
  input  wire logic                              ext_bus_low_sel_raw,
  input  wire logic                              ext_bus_high_sel_raw,
  input  wire logic                              byte_select_mode,
  output logic                                   ext_bus_low_write_strobe,
  output logic                                   ext_bus_high_write_strobe,
  // polarity control and inverted signal groups
  input  wire logic [pin_mux_pkg::POL_BITS-1:0]  polarity,
  input  wire logic [pin_mux_pkg::NUM_IRQ-1:0]   irq_pin,
  output logic [pin_mux_pkg::NUM_IRQ-1:0]        irq_req,
  input  wire logic [pin_mux_pkg::NUM_CAPT-1:0]  capt_pin,
  output logic [pin_mux_pkg::NUM_CAPT-1:0]       capt_sig,
  input  wire logic [pin_mux_pkg::NUM_CMP-1:0]   cmp_raw,
  output logic [pin_mux_pkg::NUM_CMP-1:0]        cmp_pin,
  input  wire logic                              tach_pin,
  output logic                                   tach_sig,
  input  wire logic                              estop_pin,
  output logic                                   estop_sig,
  input  wire logic [pin_mux_pkg::NUM_PHASE-1:0] phase_raw,
  output logic [pin_mux_pkg::NUM_PHASE-1:0]      phase_pin
);
  import pin_mux_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the pin index and select fields have fixed widths on the ports, so a
  // larger geometry would alias pins instead of failing loudly
  if (NUM_PINS > (1 << SEL_IDX_BITS)) begin : g_chk_index
    $error("pin index too narrow for the pin count");
  end
  if ($bits(sel_pin) != SEL_IDX_BITS) begin : g_chk_index_port
    $error("pin index port width mismatch");
  end
  if ($bits(pin_fn_e) != SEL_BITS) begin : g_chk_sel_width
    $error("select code width mismatch");
  end
  // every port that the bus can take over must exist
  if ((EXT_DATA_PORT >= NUM_PORTS) || (EXT_ADDR_MID_PORT >= NUM_PORTS) ||
      (EXT_ADDR_HI_PORT >= NUM_PORTS)) begin : g_chk_bus_ports
    $error("external bus port outside the pin range");
  end
  // the 16-bit mux bus treats its two data ports as one contiguous half-word
  if (EXT_ADDR_MID_PORT != EXT_DATA_PORT + 1) begin : g_chk_mux_pair
    $error("mux bus data ports are not adjacent");
  end
  // the byte lanes below assume one port per data byte
  if ($bits(ext_bus_wdata) != 2 * PORT_BITS) begin : g_chk_lane_width
    $error("port width does not match the bus byte lanes");
  end
  // each polarity group needs its own bit in the control vector
  if ((POL_IRQ >= POL_BITS) || (POL_ALE >= POL_BITS) || (POL_CAPT >= POL_BITS) ||
      (POL_CMP >= POL_BITS) || (POL_TACH >= POL_BITS) || (POL_ESTOP >= POL_BITS) ||
      (POL_PHASE >= POL_BITS)) begin : g_chk_polarity
    $error("polarity group outside the control vector");
  end

  // ************************************************************
  // external bus byte lanes
  // ************************************************************
  // named lanes keep the port pairing of both bus modes in one place
  logic [PORT_BITS-1:0]   addr_low_byte;
  logic [PORT_BITS-1:0]   addr_mid_byte;
  logic [PORT_BITS-1:0]   addr_high_byte;
  logic [2*PORT_BITS-1:0] addr_low_half;
  logic [PORT_BITS-1:0]   wdata_low_byte;

  assign addr_low_byte  = ext_bus_addr[EXT_LOW_LSB +: PORT_BITS];
  assign addr_mid_byte  = ext_bus_addr[EXT_MID_LSB +: PORT_BITS];
  assign addr_high_byte = ext_bus_addr[EXT_HIGH_LSB +: PORT_BITS];
  assign addr_low_half  = ext_bus_addr[EXT_LOW_LSB +: 2*PORT_BITS];
  // the 8-bit bus only ever uses the low data lane
  assign wdata_low_byte = ext_bus_wdata[EXT_LOW_LSB +: PORT_BITS];

  // ************************************************************
  // external bus pin override per port
  // ************************************************************
  logic [NUM_PINS-1:0] force_en;
  logic [NUM_PINS-1:0] force_out;
  logic [NUM_PINS-1:0] force_oe;
  logic                nonmux;
  logic                mux16;

  assign nonmux = (ext_bus_mode == 2'(bus_8bit_nonmux));
  assign mux16  = (ext_bus_mode == 2'(bus_16bit_mux));

  // bus modes take whole ports, overriding per-pin selects while active
  always_comb begin
    force_en  = '0;
    force_out = '0;
    force_oe  = '0;
    if (nonmux) begin
      // port 8 data, ports 7/9 carry sixteen address bits
      force_en [EXT_DATA_PORT*PORT_BITS +: PORT_BITS]     = '1;
      force_out[EXT_DATA_PORT*PORT_BITS +: PORT_BITS]     = wdata_low_byte;
      force_oe [EXT_DATA_PORT*PORT_BITS +: PORT_BITS]     = {PORT_BITS{ext_bus_data_oe}};
      force_en [EXT_ADDR_MID_PORT*PORT_BITS +: PORT_BITS] = '1;
      force_out[EXT_ADDR_MID_PORT*PORT_BITS +: PORT_BITS] = addr_low_byte;
      force_oe [EXT_ADDR_MID_PORT*PORT_BITS +: PORT_BITS] = '1;
      force_en [EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS]  = '1;
      force_out[EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS]  = addr_mid_byte;
      force_oe [EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS]  = '1;
    end else if (mux16) begin
      // address phase drives low address, data phase drives or releases
      force_en [EXT_DATA_PORT*PORT_BITS +: 2*PORT_BITS] = '1;
      force_out[EXT_DATA_PORT*PORT_BITS +: 2*PORT_BITS] =
        ext_bus_addr_phase ? addr_low_half : ext_bus_wdata;
      force_oe [EXT_DATA_PORT*PORT_BITS +: 2*PORT_BITS] =
        {2*PORT_BITS{ext_bus_addr_phase | ext_bus_data_oe}};
      force_en [EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS] = '1;
      force_out[EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS] = addr_high_byte;
      force_oe [EXT_ADDR_HI_PORT*PORT_BITS +: PORT_BITS] = '1;
    end
  end

  // ************************************************************
  // per-pin cells
  // ************************************************************
  logic [NUM_PINS-1:0] alt_in_en;

  // a write to an index past the last pin matches no cell and is dropped
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_cell u_cell (
      .clk       (clk),
      .nrst      (nrst),
      .sel_we    (sel_we && (sel_pin == SEL_IDX_BITS'(i))),
      .sel_wdata (sel_wdata),
      .alt_out1  (alt_out1[i]),
      .alt_out2  (alt_out2[i]),
      .alt_out3  (alt_out3[i]),
      .force_out (force_out[i]),
      .force_oe  (force_oe[i]),
      .force_en  (force_en[i]),
      .sel_q     (sel_state[i*SEL_BITS +: SEL_BITS]),
      .pin_out   (pad_out[i]),
      .pin_oe    (pad_oe[i]),
      .alt_in_en (alt_in_en[i])
    );
    // default input path lives only while the pin keeps its reset select
    assign default_in[i] = (sel_state[i*SEL_BITS +: SEL_BITS] == FN_RESET) & pad_in[i];
    assign alt_in[i]     = alt_in_en[i] & pad_in[i];
  end

  // ************************************************************
  // general input sampling
  // ************************************************************
  // sampled regardless of select so outputs can be read back too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_in_q <= '0;
    end else begin
      gpio_in_q <= pad_in;
    end
  end

  // bus read data captured from ports 8 and 9; the 8-bit bus has no
  // upper data lane, so that byte always reads as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_bus_rdata_q <= '0;
    end else if (nonmux) begin
      ext_bus_rdata_q <= {{PORT_BITS{1'b0}}, pad_in[EXT_DATA_PORT*PORT_BITS +: PORT_BITS]};
    end else if (mux16) begin
      ext_bus_rdata_q <= pad_in[EXT_DATA_PORT*PORT_BITS +: 2*PORT_BITS];
    end
  end

  // ************************************************************
  // polarity and strobe options
  // ************************************************************
  // xor keeps each group at one gate of delay
  assign irq_req            = irq_pin  ^ {NUM_IRQ{polarity[POL_IRQ]}};
  assign capt_sig           = capt_pin ^ {NUM_CAPT{polarity[POL_CAPT]}};
  assign cmp_pin            = cmp_raw  ^ {NUM_CMP{polarity[POL_CMP]}};
  assign tach_sig           = tach_pin ^ polarity[POL_TACH];
  assign estop_sig          = estop_pin ^ polarity[POL_ESTOP];
  assign phase_pin          = phase_raw ^ {NUM_PHASE{polarity[POL_PHASE]}};
  assign ext_bus_addr_latch = ext_bus_addr_latch_raw ^ polarity[POL_ALE];

  // byte selects share the strobe pins
  assign ext_bus_low_write_strobe  =
    byte_select_mode ? ext_bus_low_sel_raw : ext_bus_low_wr_raw;
  assign ext_bus_high_write_strobe =
    byte_select_mode ? ext_bus_high_sel_raw : ext_bus_high_wr_raw;
endmodule

/* testbench/pin_board_model.sv */
// ****************************************
// board wiring seen by the pads
// ****************************************
module pin_board_model
(
  input wire logic [79:0] pad_out,
  input wire logic [79:0] pad_oe,
  input wire logic [79:0] board_level,
  output logic [79:0]     pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // no pull-ups: an undriven pin shows only the board's own level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule

/* testbench/pin_mux_assertions.sv */
// ****************************************
// pin mux port checker
// ****************************************
module pin_mux_assertions
(
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic [239:0] sel_state,
  input wire logic [79:0]  pad_in,
  input wire logic [79:0]  pad_out,
  input wire logic [79:0]  pad_oe,
  input wire logic [79:0]  gpio_in_q,
  input wire logic [79:0]  default_in,
  input wire logic [1:0]   ext_bus_mode,
  input wire logic [23:0]  ext_bus_addr,
  input wire logic         byte_select_mode,
  input wire logic         ext_bus_low_wr_raw,
  input wire logic         ext_bus_low_sel_raw,
  input wire logic         ext_bus_low_write_strobe,
  input wire logic [6:0]   polarity,
  input wire logic [7:0]   irq_pin,
  input wire logic [7:0]   irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [79:0] oe_exp;
  logic [79:0] dflt_m;
  // masks from the registered selects; codes 5-7 must stay undriven too
  always_comb begin
    for (int i = 0; i < 80; i++) begin
      oe_exp[i] = sel_state[i*3+:3] inside {3'h2, 3'h3, 3'h4};
      dflt_m[i] = sel_state[i*3+:3] == 3'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_all_input: assert property ($rose(nrst) |-> pad_oe == 80'h0)
    else $error("pin driven after reset");
  // bus modes 0 and 3 leave every port to the per-pin selects
  a_oe_from_sel: assert property (
    ext_bus_mode[0] == ext_bus_mode[1] |-> pad_oe == oe_exp)
    else $error("output enable disagrees with select");
  a_gpio_live_read: assert property (1'b1 |=> gpio_in_q == $past(pad_in))
    else $error("gpio read lost pin level");
  a_default_route: assert property (default_in == (pad_in & dflt_m))
    else $error("default input routing wrong");
  a_nonmux_addr: assert property (
    ext_bus_mode == 2'h1 |-> pad_oe[63:56] == 8'hFF && pad_out[63:56] == ext_bus_addr[15:8])
    else $error("nonmux address byte wrong");
  a_mux_high_addr: assert property (
    ext_bus_mode == 2'h2 |-> pad_out[63:56] == ext_bus_addr[23:16])
    else $error("mux high address wrong");
  a_irq_polarity: assert property (irq_req == (irq_pin ^ {8{polarity[0]}}))
    else $error("irq polarity wrong");
  a_strobe_select: assert property (
    ext_bus_low_write_strobe == (byte_select_mode ? ext_bus_low_sel_raw : ext_bus_low_wr_raw))
    else $error("low strobe pin source wrong");
endmodule

bind port_pin_function_mux pin_mux_assertions chk (
  .clk, .nrst, .sel_state, .pad_in, .pad_out, .pad_oe, .gpio_in_q, .default_in,
  .ext_bus_mode, .ext_bus_addr, .byte_select_mode, .ext_bus_low_wr_raw,
  .ext_bus_low_sel_raw, .ext_bus_low_write_strobe, .polarity, .irq_pin, .irq_req
);

/* testbench/port_pin_function_mux_bench.sv */
// ****************************************
// pin mux bench
// ****************************************
module port_pin_function_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  logic clk, nrst, sel_we, ext_bus_data_oe, ext_bus_addr_phase, byte_select_mode;
  logic ext_bus_addr_latch_raw, ext_bus_addr_latch, tach_pin, tach_sig, estop_pin, estop_sig;
  logic ext_bus_low_wr_raw, ext_bus_high_wr_raw, ext_bus_low_sel_raw, ext_bus_high_sel_raw;
  logic ext_bus_low_write_strobe, ext_bus_high_write_strobe;
  logic [6:0]   sel_pin, polarity;
  logic [2:0]   sel_wdata;
  logic [1:0]   ext_bus_mode;
  logic [23:0]  ext_bus_addr;
  logic [15:0]  ext_bus_wdata, ext_bus_rdata_q;
  logic [7:0]   irq_pin, irq_req, capt_pin, capt_sig, cmp_raw, cmp_pin;
  logic [5:0]   phase_raw, phase_pin;
  logic [239:0] sel_state;
  logic [79:0]  board_level, pad_in, pad_out, pad_oe, gpio_in_q, default_in, alt_in;
  logic [79:0]  alt_out1, alt_out2, alt_out3;
  int           num_errors = 0;
  int           check_count = 0;
  int           cycles = 0;

  port_pin_function_mux DUT (.*);
  pin_board_model board (.*);

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run is about 40 cycles, so 500 means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // caller drops sel_we after a burst, so back-to-back writes never glitch it
  task automatic wr_sel(input int pin, input logic [2:0] code);
    sel_pin = pin[6:0];
    sel_wdata = code;
    sel_we = 1'b1;
    @(negedge clk);
  endtask
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {nrst, sel_we, ext_bus_data_oe, ext_bus_addr_phase, byte_select_mode, tach_pin} = '0;
    {ext_bus_addr_latch_raw, estop_pin, ext_bus_low_wr_raw, ext_bus_high_wr_raw} = '0;
    {ext_bus_low_sel_raw, ext_bus_high_sel_raw, sel_pin, polarity, sel_wdata} = '0;
    {ext_bus_mode, ext_bus_addr, ext_bus_wdata, irq_pin, capt_pin, cmp_raw, phase_raw} = '0;
    board_level = {10{8'h3C}};
    {alt_out1, alt_out2, alt_out3} = {80'h0, {80{1'b1}}, 80'h0};
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check(pad_oe, 80'h0);
    check(default_in, board_level);
    check(gpio_in_q, board_level);
    // every select code once, pins 10..17
    for (int c = 0; c < 8; c++) wr_sel(10 + c, c[2:0]);
    sel_we = 1'b0;
    check(sel_state[53:30], 80'hFAC688);
    check(pad_oe[17:10], 80'h1C);
    check(pad_out[14:12], 80'h2);
    check(default_in[17:10], 80'h1);
    check(alt_in[17:10], 80'h2);
    @(negedge clk);
    check(gpio_in_q[17:10], 80'h0B);
    wr_sel(12, 3'h0);
    sel_we = 1'b0;
    check({pad_oe[12], default_in[12]}, 80'h1);
    // 8-bit nonmux then 16-bit mux bus traffic
    {ext_bus_mode, ext_bus_addr, ext_bus_wdata} = {2'h1, 24'hABCDEF, 16'h1234};
    ext_bus_data_oe = 1'b1;
    @(negedge clk);
    check({pad_out[63:56], pad_out[79:72], pad_out[71:64]}, 80'hCDEF34);
    check(pad_oe[79:56], 80'hFFFFFF);
    ext_bus_data_oe = 1'b0;
    @(negedge clk);
    check(ext_bus_rdata_q, 80'h3C);
    {ext_bus_mode, ext_bus_addr_phase, ext_bus_data_oe} = {2'h2, 1'b1, 1'b1};
    @(negedge clk);
    check({pad_out[63:56], pad_out[79:72], pad_out[71:64]}, 80'hABCDEF);
    ext_bus_addr_phase = 1'b0;
    @(negedge clk);
    check(pad_out[79:64], 80'h1234);
    ext_bus_data_oe = 1'b0;
    @(negedge clk);
    check(ext_bus_rdata_q, 80'h3C3C);
    ext_bus_mode = 2'h3;
    @(negedge clk);
    check(pad_oe[79:56], 80'h0);
    // two complementary polarity patterns catch swapped group bits
    for (int p = 0; p < 2; p++) begin
      polarity = p ? 7'h2A : 7'h55;
      {irq_pin, capt_pin, cmp_raw, phase_raw} = 30'h12345678;
      {tach_pin, estop_pin, ext_bus_addr_latch_raw} = 3'h5;
      @(negedge clk);
      check({irq_req, capt_sig, cmp_pin}, {irq_pin ^ {8{polarity[0]}},
        capt_pin ^ {8{polarity[2]}}, cmp_raw ^ {8{polarity[3]}}});
      check({tach_sig, estop_sig, ext_bus_addr_latch, phase_pin}, {tach_pin ^ polarity[4],
        estop_pin ^ polarity[5], ext_bus_addr_latch_raw ^ polarity[1],
        phase_raw ^ {6{polarity[6]}}});
    end
    for (int b = 0; b < 2; b++) begin
      byte_select_mode = b[0];
      {ext_bus_low_wr_raw, ext_bus_high_wr_raw, ext_bus_low_sel_raw, ext_bus_high_sel_raw} = 4'h9;
      @(negedge clk);
      check({ext_bus_low_write_strobe, ext_bus_high_write_strobe}, b ? 80'h1 : 80'h2);
    end
    // reset in mid-run drops a live output
    wr_sel(20, 3'h2);
    sel_we = 1'b0;
    check(pad_oe[20], 80'h1);
    nrst = 1'b0;
    @(negedge clk);
    check(pad_oe, 80'h0);
    nrst = 1'b1;
    @(negedge clk);
    check(pad_oe, 80'h0);
    end_sim();
  end
endmodule
